/* hw/pcps_config_power.sv */
`timescale 1ns/10ps
// Behaviour
// (RULE1) D0 gives full function, mastering and interrupts
// (RULE2) frames guaranteed only with clock at least 16MHz
// (RULE3) D1, D2, D3hot answer configuration accesses only
// (RULE4) low power: no network activity except wake
// (RULE5) after power loss, reset brings D0 defaults
// (RULE6) host reinitialises fully after D3hot to D0
// (RULE7) D3hot still answers configuration cycles
// (RULE8) D3hot to D0 triggers internal power-up reset
// (RULE9) hardware reset loads configuration register defaults
// (RULE10) software reset leaves configuration registers unchanged
// (RULE11) byte, word and dword configuration accesses
// (RULE12) identifiers and latency fields loaded from EEPROM
// (RULE13) scratch bits 15 to 8 read/write
// (RULE14) signature register is a fixed constant
// (RULE15) boot ROM base decodes a 128Kbit window
// (RULE16) power capability at c0h, control at c4h
// (RULE17) I/O and memory window bases at 10h, 14h
// (RULE18) 08h reports class, subclass, revision and step
// (RULE19) D2/D3hot no frames; config only in B0/B1
// (RULE20) power-state write applies restrictions once complete
module pcps_config_power
	import pcps_pkg::*;
#(
	parameter logic [7:0]  REVISION  = 8'h01,        // arbitrary value
	parameter logic [7:0]  STEP      = 8'h00,        // arbitrary value
	parameter logic [31:0] SIGNATURE = 32'h0000_0001 // arbitrary value
) (
	input  wire logic        sys_clk,          // bus clock
	input  wire logic        arst_n,           // bus reset, active low
	input  wire logic        cfgReq,           // configuration cycle
	input  wire logic        cfgWrite,         // 1 write, 0 read
	input  wire logic [7:0]  cfgAddr,          // byte address
	input  wire logic [3:0]  cfgByteEn,        // byte lanes
	input  wire logic [31:0] cfgWdata,         // write data
	output logic             cfgAck,           // access answered
	output logic      [31:0] cfgRdata,         // read data
	input  wire logic [1:0]  busState,         // bus power state
	input  wire logic        targetReq,        // I/O or memory cycle
	input  wire logic        targetIsIo,       // 1 I/O, 0 memory
	output logic             targetClaim,      // cycle claimed
	input  wire logic        eeLoad,           // EEPROM values valid
	input  wire logic [15:0] eeDeviceId,       // device id
	input  wire logic [15:0] eeVendorId,       // vendor id
	input  wire logic [15:0] eeSubsysId,       // subsystem id
	input  wire logic [15:0] eeSubsysVendorId, // subsystem vendor id
	input  wire logic [7:0]  eeMaxLat,         // maximum latency
	input  wire logic [7:0]  eeMinGnt,         // minimum grant
	input  wire logic        swResetReq,       // software reset pulse
	input  wire logic        parityErr,        // parity error pulse
	input  wire logic        wakePin,          // wake event pin
	output logic      [1:0]  powerState,       // device power state
	output logic             txEnable,         // transmit allowed
	output logic             rxEnable,         // receive allowed
	output logic             masterEnable,     // may start cycles
	output logic             intAllowed,       // may interrupt
	output logic             wakeDetectEnable, // wake logic armed
	output logic             pmeAssert,        // wake request
	output logic             macReset          // datapath reset
);
	////////////////////////////////////////////////////////////////////////
	// registers
	pcps_pstate_t powerState_q;
	logic [31:0]  idReg_q;
	logic [31:0]  subsysReg_q;
	logic [15:0]  busTiming_q;
	logic [15:0]  command_q;
	logic         parityStat_q;
	logic [31:0]  latReg_q;
	logic [31:0]  ioBase_q;
	logic [31:0]  memBase_q;
	logic [31:0]  romBase_q;
	logic [7:0]   intLine_q;
	logic [7:0]   scratch_q;
	logic         pmeEn_q;
	logic         pmeStat_q;
	logic         funcReset_q;
	logic         cfgAck_q;
	logic [31:0]  cfgRdata_q;
	logic         targetClaim_q;
	logic         txEnable_q;
	logic         rxEnable_q;
	logic         masterEnable_q;
	logic         intAllowed_q;
	logic         wakeDetect_q;
	logic         pmeAssert_q;
	logic         macReset_q;
	logic         wakeLevelPrev_q;
	logic         wakeLevel, wakeEvent, cfgOk, cfgWr, lowPower;
	logic         hitCmd, hitPmcsr, leaveD3hot;
	logic [31:0]  curValue, curMask, mergedValue;

	////////////////////////////////////////////////////////////////////////
	// access qualification
	assign cfgOk      = cfgReq
		&& (busState == BS_B0 || busState == BS_B1); // see (RULE19)
	assign cfgWr      = cfgOk && cfgWrite;
	assign hitCmd     = cfgAddr[7:2] == OFF_CMD[7:2];
	assign hitPmcsr   = cfgAddr[7:2] == OFF_PMCSR[7:2];
	assign lowPower   = powerState_q != PS_D0;
	assign leaveD3hot = cfgWr && hitPmcsr && cfgByteEn[0]
		&& powerState_q == PS_D3HOT && cfgWdata[1:0] == PS_D0; // see (RULE8)

	////////////////////////////////////////////////////////////////////////
	// current value and writable mask of the addressed register
	always_comb begin
		curValue = 32'h0000_0000;
		curMask  = 32'h0000_0000;
		case (cfgAddr[7:2])
			OFF_ID[7:2]:      curValue = idReg_q; // see (RULE12)
			OFF_CMD[7:2]: begin
				curValue = {parityStat_q, STATUS_FIXED[14:0], command_q};
				curMask  = MASK_CMD;
			end
			OFF_CLASS[7:2]: begin
				curValue = {CLASS_BASE, CLASS_SUB, REVISION, STEP}; // see (RULE18)
			end
			OFF_LAT[7:2]: begin
				curValue = latReg_q;
				curMask  = MASK_LAT;
			end
			OFF_IOBASE[7:2]: begin
				curValue = ioBase_q | IOBASE_FIXED; // see (RULE17)
				curMask  = MASK_IOBASE;
			end
			OFF_MEMBASE[7:2]: begin
				curValue = memBase_q; // see (RULE17)
				curMask  = MASK_MEMBASE;
			end
			OFF_SUBSYS[7:2]:  curValue = subsysReg_q; // see (RULE12)
			OFF_ROM[7:2]: begin
				curValue = romBase_q; // see (RULE15)
				curMask  = MASK_ROM;
			end
			OFF_CAPPTR[7:2]: begin
				curValue = {24'h00_0000, OFF_PMCAP}; // see (RULE16)
			end
			OFF_INTCFG[7:2]: begin
				curValue = {busTiming_q, INT_PIN_A, intLine_q};
				curMask  = MASK_INTCFG;
			end
			OFF_SCRATCH[7:2]: begin
				curValue = {16'h0000, scratch_q, 8'h00}; // see (RULE13)
				curMask  = MASK_SCRATCH;
			end
			OFF_SIG[7:2]:     curValue = SIGNATURE; // see (RULE14)
			OFF_PMCAP[7:2]: begin
				curValue = {PM_CAPS, CAP_NEXT, CAP_ID_PM}; // see (RULE16)
			end
			OFF_PMCSR[7:2]: begin
				curValue = {16'h0000, pmeStat_q, 6'h00, pmeEn_q,
					6'h00, powerState_q};
				curMask  = MASK_PMCSR;
			end
			default: curValue = 32'h0000_0000;
		endcase
	end

	pcps_byte_merge uMerge (
		.oldValue  (curValue),
		.newValue  (cfgWdata),
		.byteEn    (cfgByteEn),
		.writeMask (curMask),
		.merged    (mergedValue)
	); // see (RULE11)

	pcps_pin_sync uWakeSync (
		.sys_clk  (sys_clk),
		.arst_n   (arst_n),
		.pinIn    (wakePin),
		.levelOut (wakeLevel)
	);

	assign wakeEvent = wakeLevel && !wakeLevelPrev_q;

	////////////////////////////////////////////////////////////////////////
	// configuration answer; no software reset input reaches any of this
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cfgAck_q   <= 1'b0;
			cfgRdata_q <= 32'h0000_0000;
		end else begin
			cfgAck_q <= cfgOk; // see (RULE7)
			if (cfgOk && !cfgWrite) begin
				cfgRdata_q <= curValue;
			end
		end
	end

	// EEPROM values survive the internal reset; they would reload the same
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			idReg_q     <= REG_RESET;
			subsysReg_q <= REG_RESET;
			busTiming_q <= REG_RESET[15:0];
		end else if (eeLoad) begin
			idReg_q     <= {eeDeviceId, eeVendorId}; // see (RULE12)
			subsysReg_q <= {eeSubsysId, eeSubsysVendorId};
			busTiming_q <= {eeMaxLat, eeMinGnt};
		end
	end

	// writable registers; defaults on pin reset and on leaving D3hot
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			command_q <= REG_RESET[15:0]; // see (RULE9)
			latReg_q  <= REG_RESET;
			ioBase_q  <= REG_RESET;
			memBase_q <= REG_RESET;
			romBase_q <= REG_RESET;
			intLine_q <= REG_RESET[7:0];
			scratch_q <= REG_RESET[7:0];
			pmeEn_q   <= 1'b0;
		end else if (funcReset_q) begin
			command_q <= REG_RESET[15:0]; // see (RULE8)
			latReg_q  <= REG_RESET;
			ioBase_q  <= REG_RESET;
			memBase_q <= REG_RESET;
			romBase_q <= REG_RESET;
			intLine_q <= REG_RESET[7:0];
			scratch_q <= REG_RESET[7:0];
			pmeEn_q   <= 1'b0;
		end else if (cfgWr) begin
			case (cfgAddr[7:2])
				OFF_CMD[7:2]:     command_q <= mergedValue[15:0];
				OFF_LAT[7:2]:     latReg_q  <= mergedValue;
				OFF_IOBASE[7:2]:  ioBase_q  <= mergedValue & MASK_IOBASE;
				OFF_MEMBASE[7:2]: memBase_q <= mergedValue;
				OFF_ROM[7:2]:     romBase_q <= mergedValue; // see (RULE15)
				OFF_INTCFG[7:2]:  intLine_q <= mergedValue[7:0];
				OFF_SCRATCH[7:2]: scratch_q <= mergedValue[15:8]; // see (RULE13)
				OFF_PMCSR[7:2]:   pmeEn_q   <= mergedValue[PM_PME_EN];
				default: ;
			endcase
		end
	end

	// sticky flags: a set in the cycle of a write-one clear wins
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			parityStat_q <= 1'b0;
			pmeStat_q    <= 1'b0;
		end else begin
			if (parityErr) begin
				parityStat_q <= 1'b1;
			end else if (cfgWr && hitCmd && cfgByteEn[3]
					&& cfgWdata[STAT_PARITY]) begin
				parityStat_q <= 1'b0;
			end
			if (wakeEvent && wakeDetect_q) begin
				pmeStat_q <= 1'b1; // see (RULE4)
			end else if (cfgWr && hitPmcsr && cfgByteEn[1]
					&& cfgWdata[PM_PME_STAT]) begin
				pmeStat_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// power state; takes effect at the edge that completes the write
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			powerState_q <= PS_D0; // see (RULE5)
			funcReset_q  <= 1'b0;
		end else begin
			funcReset_q <= leaveD3hot; // see (RULE8)
			if (cfgWr && hitPmcsr && cfgByteEn[0]) begin
				case (cfgWdata[1:0])
					PS_D0:    powerState_q <= PS_D0; // see (RULE20)
					PS_D1:    powerState_q <= PS_D1;
					PS_D2:    powerState_q <= PS_D2;
					PS_D3HOT: powerState_q <= PS_D3HOT;
					default:  powerState_q <= powerState_q;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// what each power state permits
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			targetClaim_q  <= 1'b0;
			txEnable_q     <= 1'b0;
			rxEnable_q     <= 1'b0;
			masterEnable_q <= 1'b0;
			intAllowed_q   <= 1'b0;
			wakeDetect_q   <= 1'b0;
			pmeAssert_q    <= 1'b0;
			macReset_q     <= 1'b0;
		end else begin
			// memory and I/O windows answer only in D0
			targetClaim_q <= targetReq && !lowPower && (targetIsIo
				? command_q[CMD_IO_EN] : command_q[CMD_MEM_EN]); // see (RULE3)
			// below the least clock rate frames are not trusted
			txEnable_q     <= !lowPower && FRAME_CLK_OK; // see (RULE2)
			rxEnable_q     <= !lowPower && FRAME_CLK_OK; // see (RULE19)
			masterEnable_q <= !lowPower && command_q[CMD_MASTER_EN]; // see (RULE1)
			intAllowed_q   <= !lowPower; // see (RULE1)
			wakeDetect_q   <= lowPower && pmeEn_q; // see (RULE4)
			pmeAssert_q    <= pmeStat_q && pmeEn_q;
			macReset_q     <= swResetReq || funcReset_q; // see (RULE10)
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			wakeLevelPrev_q <= 1'b0;
		end else begin
			wakeLevelPrev_q <= wakeLevel;
		end
	end

	assign cfgAck           = cfgAck_q;
	assign cfgRdata         = cfgRdata_q;
	assign targetClaim      = targetClaim_q;
	assign powerState       = powerState_q;
	assign txEnable         = txEnable_q;
	assign rxEnable         = rxEnable_q;
	assign masterEnable     = masterEnable_q;
	assign intAllowed       = intAllowed_q;
	assign wakeDetectEnable = wakeDetect_q;
	assign pmeAssert        = pmeAssert_q;
	assign macReset         = macReset_q;

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cbMain @(posedge sys_clk);
	endclocking
	default disable iff (!arst_n);

	a_cfg_answered: assert property ( // see (RULE7)
		cfgOk |=> cfgAck_q)
		else $error("configuration cycle not answered");
	a_cfg_bus_refused: assert property ( // see (RULE19)
		cfgReq && (busState == BS_B2 || busState == BS_B3) |=> !cfgAck_q)
		else $error("configuration cycle answered in B2 or B3");
	a_target_low_power: assert property ( // see (RULE3)
		lowPower |=> !targetClaim_q)
		else $error("memory or I/O cycle claimed in low power");
	a_net_low_power: assert property ( // see (RULE4)
		lowPower |=> !txEnable_q && !rxEnable_q && !masterEnable_q)
		else $error("network activity allowed in low power");
	a_d3hot_exit: assert property ( // see (RULE8)
		leaveD3hot |=> funcReset_q && powerState_q == PS_D0
			##1 !funcReset_q && command_q == 16'h0000 && macReset_q)
		else $error("leaving D3hot did not reset the function");
	a_signature_read: assert property ( // see (RULE14)
		cfgOk && !cfgWrite && cfgAddr[7:2] == OFF_SIG[7:2]
			|=> cfgRdata_q == SIGNATURE)
		else $error("signature read wrong");
	a_scratch_bits: assert property ( // see (RULE13)
		cfgOk && !cfgWrite && cfgAddr[7:2] == OFF_SCRATCH[7:2]
			|=> cfgRdata_q[7:0] == 8'h00 && cfgRdata_q[31:16] == 16'h0000)
		else $error("scratch reserved bits not zero");
	a_cap_pointer: assert property ( // see (RULE16)
		cfgOk && !cfgWrite && cfgAddr[7:2] == OFF_CAPPTR[7:2]
			|=> cfgRdata_q == {24'h00_0000, OFF_PMCAP})
		else $error("capability pointer wrong");
	a_swreset_keeps: assert property ( // see (RULE10)
		swResetReq && !cfgWr && !funcReset_q
			|=> $stable(command_q) && $stable(ioBase_q) && $stable(scratch_q))
		else $error("software reset changed configuration");
	a_state_write: assert property ( // see (RULE20)
		cfgWr && hitPmcsr && cfgByteEn[0]
			|=> powerState_q == $past(cfgWdata[1:0]))
		else $error("power state write not applied");
endmodule

/* shared/pcps_pkg.sv */
package pcps_pkg;

	////////////////////////////////////////////////////////////////////////
	// configuration register offsets (byte addresses)
	localparam logic [7:0] OFF_ID      = 8'h00;
	localparam logic [7:0] OFF_CMD     = 8'h04;
	localparam logic [7:0] OFF_CLASS   = 8'h08;
	localparam logic [7:0] OFF_LAT     = 8'h0C;
	localparam logic [7:0] OFF_IOBASE  = 8'h10;
	localparam logic [7:0] OFF_MEMBASE = 8'h14;
	localparam logic [7:0] OFF_SUBSYS  = 8'h2C;
	localparam logic [7:0] OFF_ROM     = 8'h30;
	localparam logic [7:0] OFF_CAPPTR  = 8'h34;
	localparam logic [7:0] OFF_INTCFG  = 8'h3C;
	localparam logic [7:0] OFF_SCRATCH = 8'h40;
	localparam logic [7:0] OFF_SIG     = 8'h80;
	localparam logic [7:0] OFF_PMCAP   = 8'hC0;
	localparam logic [7:0] OFF_PMCSR   = 8'hC4;

	////////////////////////////////////////////////////////////////////////
	// bits software may write, per register
	localparam logic [31:0] MASK_CMD     = 32'h0000_0147;
	localparam logic [31:0] MASK_LAT     = 32'h0000_FFFF;
	localparam logic [31:0] MASK_IOBASE  = 32'hFFFF_FF80;
	localparam logic [31:0] MASK_MEMBASE = 32'hFFFF_FF80;
	localparam logic [31:0] MASK_ROM     = 32'hFFFF_C001;
	localparam logic [31:0] MASK_INTCFG  = 32'h0000_00FF;
	localparam logic [31:0] MASK_SCRATCH = 32'h0000_FF00;
	localparam logic [31:0] MASK_PMCSR   = 32'h0000_0103;

	////////////////////////////////////////////////////////////////////////
	// fixed field values and reset values
	localparam logic [15:0] STATUS_FIXED  = 16'h0290;
	localparam logic [31:0] IOBASE_FIXED  = 32'h0000_0001;
	localparam logic [31:0] REG_RESET     = 32'h0000_0000;
	localparam logic [7:0]  CLASS_BASE    = 8'h02;
	localparam logic [7:0]  CLASS_SUB     = 8'h00;
	localparam logic [7:0]  CAP_ID_PM     = 8'h01;
	localparam logic [7:0]  CAP_NEXT      = 8'h00;
	localparam logic [15:0] PM_CAPS       = 16'h0002;
	localparam logic [7:0]  INT_PIN_A     = 8'h01;

	// bit positions
	localparam int CMD_IO_EN     = 0;
	localparam int CMD_MEM_EN    = 1;
	localparam int CMD_MASTER_EN = 2;
	localparam int STAT_PARITY   = 31;
	localparam int PM_PME_EN     = 8;
	localparam int PM_PME_STAT   = 15;

	////////////////////////////////////////////////////////////////////////
	// clock rate against the least rate for frame handling
	localparam int CLK_PERIOD_NS     = 10;
	localparam int CLK_FREQ_MHZ      = 1000 / CLK_PERIOD_NS;
	localparam int MIN_FRAME_CLK_MHZ = 16;
	localparam bit FRAME_CLK_OK      = CLK_FREQ_MHZ >= MIN_FRAME_CLK_MHZ;

	typedef enum logic [1:0] {
		PS_D0    = 2'b00,
		PS_D1    = 2'b01,
		PS_D2    = 2'b10,
		PS_D3HOT = 2'b11
	} pcps_pstate_t;

	typedef enum logic [1:0] {
		BS_B0 = 2'b00,
		BS_B1 = 2'b01,
		BS_B2 = 2'b10,
		BS_B3 = 2'b11
	} pcps_bstate_t;

endpackage

/* hw/pcps_pin_sync.sv */
`timescale 1ns/10ps
module pcps_pin_sync (
	input  wire logic sys_clk,  // system clock
	input  wire logic arst_n,   // async reset, active low
	input  wire logic pinIn,    // raw pin level
	output logic      levelOut  // filtered level
);
	logic [2:0] stage_q;
	logic       level_q;

	// first stage feeds only the second
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			stage_q <= 3'h0;
		end else begin
			stage_q <= {stage_q[1:0], pinIn};
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			level_q <= 1'b0;
		end else if (stage_q[1] == stage_q[2]) begin
			level_q <= stage_q[2];
		end
	end

	assign levelOut = level_q;
endmodule

/* hw/pcps_byte_merge.sv */
`timescale 1ns/10ps
module pcps_byte_merge (
	input  wire logic [31:0] oldValue,  // current register contents
	input  wire logic [31:0] newValue,  // write data from the bus
	input  wire logic [3:0]  byteEn,    // byte lanes written
	input  wire logic [31:0] writeMask, // bits software may change
	output logic      [31:0] merged     // value to store
);
	genvar lane;
	generate
		for (lane = 0; lane < 4; lane++) begin : gLane
			// a byte, word or dword write touches only its own lanes
			assign merged[lane*8 +: 8] = byteEn[lane]
				? ((newValue[lane*8 +: 8] & writeMask[lane*8 +: 8])
				 | (oldValue[lane*8 +: 8] & ~writeMask[lane*8 +: 8]))
				: oldValue[lane*8 +: 8];
		end
	endgenerate
endmodule

/* verif/pcps_host_model.sv */
`timescale 1ns/10ps
module pcps_host_model (
	input  wire logic        sys_clk,   // bus clock
	output logic             cfgReq,    // configuration cycle
	output logic             cfgWrite,  // 1 write, 0 read
	output logic      [7:0]  cfgAddr,   // byte address
	output logic      [3:0]  cfgByteEn, // byte lanes
	output logic      [31:0] cfgWdata,  // write data
	input  wire logic        cfgAck,    // access answered
	input  wire logic [31:0] cfgRdata   // read data
);
	initial begin
		cfgReq = 1'b0;
		cfgWrite = 1'b0;
		cfgAddr = 8'h00;
		cfgByteEn = 4'h0;
		cfgWdata = 32'h0000_0000;
	end

	////////////////////////////////////////////////////////////////////
	// one pulse per access; the released lines carry the inverse of the
	// last value so a late sample cannot pass by luck
	task automatic access(input logic wr, input logic [7:0] addr,
		input logic [3:0] be, input logic [31:0] wd,
		output logic [31:0] rd, output logic ack);
		@(posedge sys_clk);
		cfgReq <= 1'b1;
		cfgWrite <= wr;
		cfgAddr <= addr;
		cfgByteEn <= be;
		cfgWdata <= wd;
		@(posedge sys_clk);
		cfgReq <= 1'b0;
		cfgWrite <= ~wr;
		cfgAddr <= ~addr;
		cfgByteEn <= ~be;
		cfgWdata <= ~wd;
		#1;
		ack = cfgAck;
		rd = cfgRdata;
	endtask

	// power state chosen through the control word only
	task automatic set_power(input logic [1:0] ps, input logic pmeEn);
		logic [31:0] d;
		logic        a;
		access(1'b1, 8'hC4, 4'h3, {23'h0, pmeEn, 6'h0, ps}, d, a);
	endtask
endmodule

/* verif/pcps_config_power_test.sv */
`timescale 1ns/10ps
module pcps_config_power_test;
	import pcps_pkg::*;
	logic        sys_clk = 1'b0, arst_n = 1'b0, cfgReq, cfgWrite, cfgAck;
	logic [7:0]  cfgAddr, eeMaxLat = 8'h92, eeMinGnt = 8'hA3;
	logic [3:0]  cfgByteEn;
	logic [31:0] cfgWdata, cfgRdata;
	logic [1:0]  busState = BS_B0, powerState;
	logic        targetReq = 1'b0, targetIsIo = 1'b0, targetClaim;
	logic        eeLoad = 1'b0, swResetReq = 1'b0, parityErr = 1'b0;
	logic        wakePin = 1'b0, txEnable, rxEnable, masterEnable;
	logic        intAllowed, wakeDetectEnable, pmeAssert, macReset;
	logic [15:0] eeDeviceId = 16'h1A2B, eeVendorId = 16'h3C4D;
	logic [15:0] eeSubsysId = 16'h5E6F, eeSubsysVendorId = 16'h7081;
	int          errors = 0, checks_done = 0;

	always #5 sys_clk = ~sys_clk;

	pcps_config_power dut (.sys_clk, .arst_n, .cfgReq, .cfgWrite, .cfgAddr,
		.cfgByteEn, .cfgWdata, .cfgAck, .cfgRdata, .busState, .targetReq,
		.targetIsIo, .targetClaim, .eeLoad, .eeDeviceId, .eeVendorId,
		.eeSubsysId, .eeSubsysVendorId, .eeMaxLat, .eeMinGnt, .swResetReq,
		.parityErr, .wakePin, .powerState, .txEnable, .rxEnable,
		.masterEnable, .intAllowed, .wakeDetectEnable, .pmeAssert,
		.macReset);
	pcps_host_model host (.sys_clk, .cfgReq, .cfgWrite, .cfgAddr,
		.cfgByteEn, .cfgWdata, .cfgAck, .cfgRdata);

	////////////////////////////////////////////////////////////////////
	task automatic test_done();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s exp %h got %h", nm, exp, got);
		end
	endtask

	task automatic rdchk(logic [7:0] a, logic [31:0] exp, logic ackExp);
		logic [31:0] d;
		logic        k;
		host.access(1'b0, a, 4'hF, 32'h0, d, k);
		chk($sformatf("ack %h", a), {31'h0, ackExp}, {31'h0, k});
		if (ackExp)
			chk($sformatf("reg %h", a), exp, d);
	endtask

	task automatic wr(logic [7:0] a, logic [3:0] be, logic [31:0] d);
		logic [31:0] r;
		logic        k;
		host.access(1'b1, a, be, d, r, k);
	endtask

	task automatic cyc(int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	// 0 EEPROM load, 1 target cycle, 2 parity error, 3 software reset
	task automatic pulse(int sel);
		@(posedge sys_clk);
		case (sel)
			0: eeLoad <= 1'b1;
			1: targetReq <= 1'b1;
			2: parityErr <= 1'b1;
			default: swResetReq <= 1'b1;
		endcase
		@(posedge sys_clk);
		{eeLoad, targetReq, parityErr, swResetReq} <= 4'h0;
		#1;
	endtask

	task automatic target(logic io, logic exp);
		targetIsIo <= io;
		pulse(1);
		chk("claim", {31'h0, exp}, {31'h0, targetClaim});
	endtask

	////////////////////////////////////////////////////////////////////
	task automatic t_defaults();
		rdchk(OFF_SIG, 32'h0000_0001, 1'b1);
		rdchk(OFF_CLASS, {CLASS_BASE, CLASS_SUB, 16'h0100}, 1'b1);
		rdchk(OFF_PMCAP, {PM_CAPS, CAP_NEXT, CAP_ID_PM}, 1'b1);
		rdchk(OFF_CAPPTR, {24'h0, OFF_PMCAP}, 1'b1);
		rdchk(OFF_SCRATCH, REG_RESET, 1'b1);
		rdchk(OFF_INTCFG, {16'h0, INT_PIN_A, 8'h00}, 1'b1);
		chk("d0", 3'b111, {txEnable, rxEnable, intAllowed});
	endtask

	task automatic t_eeprom();
		pulse(0);
		rdchk(OFF_ID, {eeDeviceId, eeVendorId}, 1'b1);
		rdchk(OFF_SUBSYS, {eeSubsysId, eeSubsysVendorId}, 1'b1);
		rdchk(OFF_INTCFG, {16'h92A3, INT_PIN_A, 8'h00}, 1'b1);
	endtask

	task automatic t_lanes();
		wr(OFF_LAT, 4'h1, 32'h1234_5678);
		rdchk(OFF_LAT, 32'h0000_0078, 1'b1);
		wr(OFF_LAT, 4'h2, 32'hAABB_CCDD);
		rdchk(OFF_LAT, 32'h0000_CC78, 1'b1);
		wr(OFF_SCRATCH, 4'hF, 32'hFFFF_FFFF);
		rdchk(OFF_SCRATCH, 32'h0000_FF00, 1'b1);
		wr(OFF_ROM, 4'hF, 32'hFFFF_FFFF);
		rdchk(OFF_ROM, 32'hFFFF_C001, 1'b1);
		wr(OFF_IOBASE, 4'hC, 32'hFFFF_FFFF);
		rdchk(OFF_IOBASE, 32'hFFFF_0001, 1'b1);
		wr(OFF_MEMBASE, 4'hF, 32'hFFFF_FFFF);
		rdchk(OFF_MEMBASE, 32'hFFFF_FF80, 1'b1);
		wr(OFF_SIG, 4'hF, 32'h0000_0000);
		rdchk(OFF_SIG, 32'h0000_0001, 1'b1);
	endtask

	task automatic t_target_parity();
		wr(OFF_CMD, 4'h1, 32'h0000_0001);
		target(1'b1, 1'b1);
		target(1'b0, 1'b0);
		wr(OFF_CMD, 4'hF, 32'h0000_0007);
		target(1'b0, 1'b1);
		chk("master", 1, masterEnable);
		pulse(2);
		rdchk(OFF_CMD, {STATUS_FIXED | 16'h8000, 16'h0007}, 1'b1);
		wr(OFF_CMD, 4'h8, 32'h8000_0000);
		rdchk(OFF_CMD, {STATUS_FIXED, 16'h0007}, 1'b1);
		pulse(3);
		chk("macReset", 1, macReset);
		rdchk(OFF_SCRATCH, 32'h0000_FF00, 1'b1);
	endtask

	task automatic t_low_power();
		for (int ps = 1; ps < 4; ps++) begin
			host.set_power(ps[1:0], 1'b1);
			cyc(1);
			chk("state", {ps[1:0], 4'h0}, {powerState, txEnable, rxEnable,
				intAllowed, masterEnable});
			target(1'b1, 1'b0);
			busState <= BS_B1;
			rdchk(OFF_SCRATCH, 32'h0000_FF00, 1'b1);
			busState <= (ps == 3) ? BS_B3 : BS_B2;
			rdchk(OFF_SCRATCH, 32'h0, 1'b0);
			busState <= BS_B0;
		end
		chk("wakeArm", 1, wakeDetectEnable);
		wakePin <= 1'b1;
		cyc(8);
		chk("pme", 1, pmeAssert);
		rdchk(OFF_PMCSR, 32'h0000_8103, 1'b1);
		wakePin <= 1'b0;
		wr(OFF_PMCSR, 4'h2, 32'h0000_8100);
		cyc(1);
		chk("pmeClear", 0, pmeAssert);
	endtask

	task automatic t_leave_d3();
		host.set_power(PS_D0, 1'b0);
		cyc(1);
		chk("internal reset", 3'b111, {macReset, txEnable, rxEnable});
		rdchk(OFF_SCRATCH, REG_RESET, 1'b1);
		rdchk(OFF_CMD, {STATUS_FIXED, 16'h0000}, 1'b1);
		rdchk(OFF_ID, {eeDeviceId, eeVendorId}, 1'b1);
		// the driver has to rebuild the command word itself
		wr(OFF_CMD, 4'h1, 32'h0000_0001);
		target(1'b1, 1'b1);
		host.set_power(PS_D2, 1'b0);
		@(posedge sys_clk);
		arst_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		arst_n <= 1'b1;
		cyc(1);
		chk("state", PS_D0, powerState);
		rdchk(OFF_ID, REG_RESET, 1'b1);
	endtask

	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(posedge sys_clk);
		arst_n <= 1'b1;
		t_defaults();
		t_eeprom();
		t_lanes();
		t_target_parity();
		t_low_power();
		t_leave_d3();
		test_done();
	end

	// the sequence needs well under a thousand cycles
	initial begin
		#20000;
		errors++;
		test_done();
	end
endmodule
